// [design/pac_cmd_top.sv]
// Parameter access command interpreter with APB register access.
// Assumes APB master semantics; frames are written as three words then issued.
`timescale 1ns/10ps
module pac_cmd_top #(
	parameter int NV_LATENCY = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] actual_position,
	output logic [31:0]      max_speed,
	output logic [7:0]       serial_addr
);
	logic [7:0]  f_addr_r, f_instr_r, f_type_r, f_bank_r, f_cksum_r;
	logic [31:0] f_value_r;
	logic        standalone_r;
	logic [31:0] accu_r, reply_value_r;
	logic [7:0]  reply_status_r, reply_instr_r;
	logic        ckerr_r;
	logic [31:0] serial_addr_r;
	logic [31:0] max_speed_r;
	logic [31:0] mod_mem_r [256];
	logic [31:0] usr_mem_r [256];
	logic [31:0] irq_mem_r [256];
	logic [7:0]  boot_idx_r;
	logic        nv_req_r, nv_we_r, nv_done;
	logic [8:0]  nv_addr_r;
	logic [31:0] nv_wdata_r, nv_rdata;
	logic [31:0] ap_rdata;
	logic        ap_we;
	logic        issue;
	logic        apb_wr, apb_rd;
	logic [7:0]  cksum_calc;
	pac_pkg::pac_state_e state_r;

	// Zero wait states: every access completes in its first access cycle.
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign issue  = apb_wr && paddr == pac_pkg::OFF_CMD_CK && state_r == pac_pkg::PAC_IDLE;

	// Modulo-256 sum of the first eight frame bytes.
	assign cksum_calc = f_addr_r + f_instr_r + f_type_r + f_bank_r + f_value_r[31:24]
		+ f_value_r[23:16] + f_value_r[15:8] + f_value_r[7:0];

	// Frame registers; value bytes arrive most significant first in the word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f_addr_r     <= 8'h00;
			f_instr_r    <= 8'h00;
			f_type_r     <= 8'h00;
			f_bank_r     <= 8'h00;
			f_value_r    <= 32'h0000_0000;
			f_cksum_r    <= 8'h00;
			standalone_r <= 1'b0;
		end else if (apb_wr) begin
			unique case (paddr)
				pac_pkg::OFF_CMD_LO: begin
					f_addr_r  <= pwdata[31:24];
					f_instr_r <= pwdata[23:16];
					f_type_r  <= pwdata[15:8];
					f_bank_r  <= pwdata[7:0];
				end
				pac_pkg::OFF_CMD_HI: f_value_r <= pwdata;
				// A checksum write while busy is refused and must not disturb the running frame.
				pac_pkg::OFF_CMD_CK: begin
					if (state_r == pac_pkg::PAC_IDLE) begin
						f_cksum_r <= pwdata[7:0];
					end
				end
				pac_pkg::OFF_CTRL: standalone_r <= pwdata[pac_pkg::CTRL_STANDALONE_BIT];
				default: ;
			endcase
		end
	end

	// Slave error on any access to unmapped words, on writes to read-only words, and on issue while busy.
	// Issue while busy is refused rather than queued: there is only one frame buffer.
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			if (paddr > pac_pkg::OFF_INSTR || paddr[1:0] != 2'b00) begin
				pslverr = 1'b1;
			end else if (pwrite && paddr > pac_pkg::OFF_CTRL) begin
				pslverr = 1'b1;
			end else if (pwrite && paddr == pac_pkg::OFF_CMD_CK && state_r != pac_pkg::PAC_IDLE) begin
				pslverr = 1'b1;
			end
		end
	end

	// Read mux; zero-wait answer.
	// Busy is taken from the state, so it is high during the boot reload as well.
	always_comb begin
		prdata = 32'h0000_0000;
		if (apb_rd) begin
			unique case (paddr)
				pac_pkg::OFF_CMD_LO: prdata = {f_addr_r, f_instr_r, f_type_r, f_bank_r};
				pac_pkg::OFF_CMD_HI: prdata = f_value_r;
				pac_pkg::OFF_CMD_CK: prdata = {24'h000000, f_cksum_r};
				pac_pkg::OFF_CTRL:   prdata = {31'h0, standalone_r};
				pac_pkg::OFF_STATUS: prdata = {22'h0, ckerr_r, state_r != pac_pkg::PAC_IDLE,
					reply_status_r};
				pac_pkg::OFF_VALUE:  prdata = reply_value_r;
				pac_pkg::OFF_ACCU:   prdata = accu_r;
				pac_pkg::OFF_INSTR:  prdata = {24'h000000, reply_instr_r};
				default:             prdata = 32'h0000_0000;
			endcase
		end
	end

	// Axis parameters: only motor 0 exists; writes stay volatile.
	assign ap_we = state_r == pac_pkg::PAC_EXEC && !ckerr_r
		&& f_instr_r == pac_pkg::SET_AXIS_PARAM_CMD && f_bank_r == 8'h00;

	// Write and read share the type field, since one frame does one or the other.
	pac_param_bank #(
		.DEPTH (256),
		.AW    (8)
	) u_axis (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (ap_we),
		.waddr   (f_type_r),
		.wdata   (f_value_r),
		.raddr   (f_type_r),
		.rdata   (ap_rdata)
	);

	// Bank 0 and bank 2 share one store: the bank bit picks the upper half.
	pac_nv_store #(
		.DEPTH   (512),
		.AW      (9),
		.LATENCY (NV_LATENCY)
	) u_nv (
		.pclk    (pclk),
		.presetn (presetn),
		.req     (nv_req_r),
		.we      (nv_we_r),
		.addr    (nv_addr_r),
		.wdata   (nv_wdata_r),
		.rdata   (nv_rdata),
		.done    (nv_done)
	);

	// Speed is mirrored in its own flop rather than read out of the array by hierarchy,
	// so the output stays a plain register and the array keeps a single read port.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			max_speed_r <= pac_pkg::ZERO32;
		end else if (ap_we && f_type_r == pac_pkg::AP_MAX_SPEED) begin
			max_speed_r <= f_value_r;
		end
	end

	// Serial bus address; serial_addr carries the low byte, replies carry all 32 bits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_addr_r <= pac_pkg::SERIAL_ADDR_RST;
		end else if (state_r == pac_pkg::PAC_EXEC && !ckerr_r
			&& f_instr_r == pac_pkg::SET_GLOBAL_PARAM_CMD && f_bank_r == pac_pkg::BANK_MODULE
			&& f_type_r == pac_pkg::GP_SERIAL_ADDR) begin
			serial_addr_r <= f_value_r;
		end
	end

	assign max_speed   = max_speed_r;
	assign serial_addr = serial_addr_r[7:0];

	// Command sequencer: boot reload, execute, optional storage access, reply.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r        <= pac_pkg::PAC_BOOT;
			boot_idx_r     <= 8'h00;
			nv_req_r       <= 1'b0;
			nv_we_r        <= 1'b0;
			nv_addr_r      <= 9'h000;
			nv_wdata_r     <= 32'h0000_0000;
			ckerr_r        <= 1'b0;
			accu_r         <= 32'h0000_0000;
			reply_value_r  <= 32'h0000_0000;
			reply_status_r <= 8'h00;
			reply_instr_r  <= 8'h00;
		end else begin
			unique case (state_r)
				pac_pkg::PAC_BOOT: begin
					// Reload one user variable per storage read after reset.
					nv_req_r  <= 1'b1;
					nv_we_r   <= 1'b0;
					nv_addr_r <= {1'b1, boot_idx_r};
					if (nv_done) begin
						nv_req_r <= 1'b0;
						if (boot_idx_r == pac_pkg::NUM_USER_VARS - 8'h01) begin
							state_r <= pac_pkg::PAC_IDLE;
						end else begin
							boot_idx_r <= boot_idx_r + 8'h01;
						end
					end
				end
				pac_pkg::PAC_IDLE: begin
					// The checksum is judged at the issuing write, against the frame held then.
					if (issue) begin
						ckerr_r <= pwdata[7:0] != cksum_calc;
						state_r <= pac_pkg::PAC_EXEC;
					end
				end
				pac_pkg::PAC_EXEC: begin
					// Defaults give an OK reply with value zero; each arm overrides what differs.
					reply_instr_r  <= f_instr_r;
					reply_status_r <= pac_pkg::ST_OK;
					reply_value_r  <= 32'h0000_0000;
					state_r        <= pac_pkg::PAC_DONE;
					// A bad checksum executes nothing: every write enable also checks ckerr_r.
					if (ckerr_r) begin
						reply_status_r <= pac_pkg::ST_BAD_CKSUM;
					end else begin
						unique case (f_instr_r)
							pac_pkg::SET_AXIS_PARAM_CMD: begin
								// Only motor 0 exists; the write itself is the ap_we strobe.
								if (f_bank_r != 8'h00) begin
									reply_status_r <= pac_pkg::ST_BAD_VALUE;
								end
							end
							pac_pkg::GET_AXIS_PARAM_CMD: begin
								// Position comes live from the input, not from the array.
								if (f_bank_r != 8'h00) begin
									reply_status_r <= pac_pkg::ST_BAD_VALUE;
								end else begin
									reply_value_r <= (f_type_r == pac_pkg::AP_ACT_POS)
										? actual_position : ap_rdata;
									if (standalone_r) begin
										accu_r <= (f_type_r == pac_pkg::AP_ACT_POS)
											? actual_position : ap_rdata;
									end
								end
							end
							pac_pkg::SET_GLOBAL_PARAM_CMD: begin
								// Array writes sit in the array process; bank 0 also needs a copy.
								unique case (f_bank_r)
									pac_pkg::BANK_MODULE: begin
										// Busy stays high until the copy lands.
										nv_req_r   <= 1'b1;
										nv_we_r    <= 1'b1;
										nv_addr_r  <= {1'b0, f_type_r};
										nv_wdata_r <= f_value_r;
										state_r    <= pac_pkg::PAC_NV_WAIT;
									end
									pac_pkg::BANK_USER, pac_pkg::BANK_IRQ_CFG: ;
									default: reply_status_r <= pac_pkg::ST_BAD_VALUE;
								endcase
							end
							pac_pkg::GET_GLOBAL_PARAM_CMD: begin
								// Global reads load the accumulator in either mode.
								unique case (f_bank_r)
									pac_pkg::BANK_MODULE: begin
										reply_value_r <= (f_type_r == pac_pkg::GP_SERIAL_ADDR)
											? serial_addr_r : mod_mem_r[f_type_r];
										accu_r <= (f_type_r == pac_pkg::GP_SERIAL_ADDR)
											? serial_addr_r : mod_mem_r[f_type_r];
									end
									pac_pkg::BANK_USER: begin
										reply_value_r <= usr_mem_r[f_type_r];
										accu_r        <= usr_mem_r[f_type_r];
									end
									pac_pkg::BANK_IRQ_CFG: begin
										reply_value_r <= irq_mem_r[f_type_r];
										accu_r        <= irq_mem_r[f_type_r];
									end
									default: reply_status_r <= pac_pkg::ST_BAD_VALUE;
								endcase
							end
							pac_pkg::STORE_GLOBAL_PARAM_CMD,
							pac_pkg::RESTORE_GLOBAL_PARAM_CMD: begin
								// Both share one storage access; only the direction differs.
								if (f_bank_r != pac_pkg::BANK_USER) begin
									reply_status_r <= pac_pkg::ST_BAD_VALUE;
								end else begin
									nv_req_r   <= 1'b1;
									nv_we_r    <= f_instr_r == pac_pkg::STORE_GLOBAL_PARAM_CMD;
									nv_addr_r  <= {1'b1, f_type_r};
									nv_wdata_r <= usr_mem_r[f_type_r];
									state_r    <= pac_pkg::PAC_NV_WAIT;
								end
							end
							default: reply_status_r <= pac_pkg::ST_BAD_CMD;
						endcase
					end
				end
				pac_pkg::PAC_NV_WAIT: begin
					// The request is held until done, so the store never sees a half access.
					if (nv_done) begin
						nv_req_r <= 1'b0;
						state_r  <= pac_pkg::PAC_DONE;
					end
				end
				pac_pkg::PAC_DONE: begin
					// The checksum flag stays up until the next issue, so software can see it.
					state_r <= pac_pkg::PAC_IDLE;
				end
			endcase
		end
	end

	// Global parameter arrays; user variables also take storage reads.
	always_ff @(posedge pclk) begin
		if (state_r == pac_pkg::PAC_EXEC && !ckerr_r
			&& f_instr_r == pac_pkg::SET_GLOBAL_PARAM_CMD) begin
			unique case (f_bank_r)
				pac_pkg::BANK_MODULE:  mod_mem_r[f_type_r] <= f_value_r;
				pac_pkg::BANK_USER:    usr_mem_r[f_type_r] <= f_value_r;
				pac_pkg::BANK_IRQ_CFG: irq_mem_r[f_type_r] <= f_value_r;
				default: ;
			endcase
		end
		// Storage reads only ever return into bank 2; bank 0 is never read back.
		if (nv_done && !nv_we_r && nv_addr_r[8]) begin
			usr_mem_r[nv_addr_r[7:0]] <= nv_rdata;
		end
	end
endmodule : pac_cmd_top

// [design/pac_nv_store.sv]
// Non-volatile word store model: one write or read per request, fixed latency.
// Assumes requests are held until done pulses; contents survive presetn.
`timescale 1ns/10ps
module pac_nv_store #(
	parameter int DEPTH   = 512,
	parameter int AW      = 9,
	parameter int LATENCY = 4
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          req,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [31:0]   wdata,
	output logic [31:0]        rdata,
	output logic               done
);
	logic [31:0] mem [DEPTH];
	logic [7:0]  cnt_r;

	// Storage array has no reset, so held values behave like a persistent copy.
	always_ff @(posedge pclk) begin
		if (req && we && cnt_r == 8'(LATENCY - 1)) begin
			mem[addr] <= wdata;
		end
	end

	// Latency counter paces each access; done is a one-cycle pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 8'h00;
			done  <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			done <= 1'b0;
			if (req && !done) begin
				if (cnt_r == 8'(LATENCY - 1)) begin
					cnt_r <= 8'h00;
					done  <= 1'b1;
					rdata <= mem[addr];
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end
endmodule : pac_nv_store

// [design/pac_param_bank.sv]
// Volatile parameter array with one write port and one combinational read port.
// Assumes the user steers writes; contents are lost on reset (axis parameters).
`timescale 1ns/10ps
module pac_param_bank #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [31:0]   wdata,
	input  wire logic [AW-1:0] raddr,
	output logic [31:0]        rdata
);
	logic [31:0] mem_r [DEPTH];

	// One generate loop builds each cleared volatile entry.
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem_r[i] <= 32'h0000_0000;
			end else if (we && waddr == AW'(i)) begin
				mem_r[i] <= wdata;
			end
		end
	end

	assign rdata = mem_r[raddr];
endmodule : pac_param_bank

// [design/pac_pkg.sv]
// Package for the parameter access command interpreter.
// Assumes a single 100 MHz clock domain and APB register access.
package pac_pkg;
	// APB register byte offsets.
	localparam logic [7:0] OFF_CMD_LO  = 8'h00; // Address, instruction, type, bank bytes.
	localparam logic [7:0] OFF_CMD_HI  = 8'h04; // Value bytes, most significant first.
	localparam logic [7:0] OFF_CMD_CK  = 8'h08; // Checksum byte; a write issues the frame.
	localparam logic [7:0] OFF_CTRL    = 8'h0C; // Bit 0 selects standalone mode.
	localparam logic [7:0] OFF_STATUS  = 8'h10; // Busy, checksum error, status code.
	localparam logic [7:0] OFF_VALUE   = 8'h14; // Reply value.
	localparam logic [7:0] OFF_ACCU    = 8'h18; // Accumulator.
	localparam logic [7:0] OFF_INSTR   = 8'h1C; // Instruction of the last reply.
	// Field positions.
	localparam int CTRL_STANDALONE_BIT = 0;
	localparam int STAT_BUSY_BIT       = 8;
	localparam int STAT_CKERR_BIT      = 9;
	// Instruction codes.
	localparam logic [7:0] SET_AXIS_PARAM_CMD      = 8'h05;
	localparam logic [7:0] GET_AXIS_PARAM_CMD      = 8'h06;
	localparam logic [7:0] SET_GLOBAL_PARAM_CMD    = 8'h09;
	localparam logic [7:0] GET_GLOBAL_PARAM_CMD    = 8'h0A;
	localparam logic [7:0] STORE_GLOBAL_PARAM_CMD  = 8'h0B;
	localparam logic [7:0] RESTORE_GLOBAL_PARAM_CMD = 8'h0C;
	// Banks and named parameters.
	localparam logic [7:0] BANK_MODULE   = 8'h00;
	localparam logic [7:0] BANK_USER     = 8'h02;
	localparam logic [7:0] BANK_IRQ_CFG  = 8'h03;
	localparam logic [7:0] GP_SERIAL_ADDR = 8'h42;
	localparam logic [7:0] AP_ACT_POS     = 8'h01;
	localparam logic [7:0] AP_MAX_SPEED   = 8'h04;
	// Status codes.
	localparam logic [7:0] ST_OK          = 8'h64;
	localparam logic [7:0] ST_BAD_CKSUM   = 8'h01;
	localparam logic [7:0] ST_BAD_CMD     = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE    = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE   = 8'h04;
	// Reset values and the boot reload count.
	localparam logic [31:0] SERIAL_ADDR_RST = 32'h0000_0001;
	localparam logic [31:0] ZERO32          = 32'h0000_0000;
	localparam logic [7:0]  NUM_USER_VARS   = 8'h38;
	// States.
	typedef enum logic [2:0] {PAC_BOOT, PAC_IDLE, PAC_EXEC, PAC_NV_WAIT, PAC_DONE} pac_state_e;
endpackage : pac_pkg

// [testbench/pac_cmd_monitor.sv]
// Checker for the APB port and parameter outputs of the command interpreter.
// Assumes it is bound to pac_cmd_top and sees only that module's ports.
`timescale 1ns/10ps
module pac_cmd_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] actual_position,
	input wire logic [31:0] max_speed,
	input wire logic [7:0]  serial_addr
);
	logic [7:0] since_r;
	logic       ctrl_r;
	// Cycles since the last accepted issue; outputs may only move shortly after one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) since_r <= 8'hFF;
		else if (psel && penable && pwrite && paddr == 8'h08 && !pslverr) since_r <= 8'h00;
		else if (since_r != 8'hFF) since_r <= since_r + 8'h01;
	end
	// Shadow of the mode bit, so read-back is judged against what was written.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctrl_r <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h0C) ctrl_r <= pwdata[0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_s; psel && penable; endsequence
	sequence ro_wr_s;
		psel && penable && pwrite && paddr inside {8'h10, 8'h14, 8'h18, 8'h1C};
	endsequence
	zero_wait_a: assert property (acc_s |-> pready) else $error("access without ready");
	unmapped_err_a: assert property (acc_s ##0 paddr > 8'h1C |-> pslverr)
		else $error("unmapped access not refused");
	ro_write_a: assert property (ro_wr_s |-> pslverr) else $error("read-only write accepted");
	mapped_ok_a: assert property (acc_s ##0 paddr inside {8'h00, 8'h04, 8'h0C} |-> !pslverr)
		else $error("mapped access refused");
	ctrl_read_a: assert property (acc_s ##0 !pwrite && paddr == 8'h0C |-> prdata[0] == ctrl_r)
		else $error("mode bit read-back wrong");
	speed_cause_a: assert property (!$stable(max_speed) |-> since_r <= 8'h14)
		else $error("speed output moved without a command");
	saddr_cause_a: assert property (!$stable(serial_addr) |-> since_r <= 8'h14)
		else $error("serial address moved without a command");
	reset_vals_a: assert property ($rose(presetn) |-> serial_addr == 8'h01 && max_speed == 32'h0)
		else $error("outputs wrong after reset");
endmodule : pac_cmd_monitor
bind pac_cmd_top pac_cmd_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .actual_position(actual_position),
	.max_speed(max_speed), .serial_addr(serial_addr));

// [testbench/pac_host_model.sv]
// Host model: drives APB transfers on behalf of a frame-sending host.
// Assumes its task is entered just after a rising edge of pclk.
`timescale 1ns/10ps
module pac_host_model (
	input wire logic         pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	output logic             hung
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		hung = 1'b0;
	end
	// One transfer: setup, then access until pready is seen high at a rising edge.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// The answer is taken at the very edge that sees pready high.
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) hung <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Released bus shows no stale value.
		pwdata <= ~d;
		// One idle edge, so back-to-back calls never assign psel twice in one step.
		@(posedge pclk);
	endtask : xfer
endmodule : pac_host_model

// [testbench/testbench.sv]
// Self-checking bench for the parameter access command interpreter.
// Assumes the host model issues APB transfers and the default storage latency.
`timescale 1ns/10ps
module testbench;
	logic        pclk;
	logic        presetn;
	logic        psel, penable, pwrite, pready, pslverr, hung;
	logic [7:0]  paddr, serial_addr;
	logic [31:0] pwdata, prdata, max_speed, actual_position, rv, acc;
	logic        er;
	int          bad_count, checks_done;
	pac_cmd_top i_pac_cmd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .actual_position(actual_position), .max_speed(max_speed),
		.serial_addr(serial_addr));
	pac_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hung(hung));
	// Free-running 100 MHz clock.
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// A hung transfer ends the run at once.
	always @(posedge pclk) if (hung === 1'b1) begin bad_count++; final_report(); end
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, rv, er);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		u_host.xfer(1'b1, a, d, rv, er);
		check("pslverr", {31'h0, er}, {31'h0, exp_err});
	endtask : wr
	// Polls until busy drops; the bound covers the boot reload too.
	task automatic wait_idle;
		int n;
		n = 0;
		do begin rd(pac_pkg::OFF_STATUS); n++; end while (rv[8] !== 1'b0 && n < 1000);
		if (n >= 1000) begin bad_count++; final_report(); end
	endtask : wait_idle
	// Sends one frame; adj spoils the checksum on purpose when nonzero.
	task automatic cmd(input logic [7:0] ins, t, b, input logic [31:0] v,
			input logic [7:0] adj, input logic [7:0] est);
		logic [7:0] ck;
		ck = 8'h01 + ins + t + b + v[31:24] + v[23:16] + v[15:8] + v[7:0] + adj;
		wr(pac_pkg::OFF_CMD_LO, {8'h01, ins, t, b}, 1'b0);
		wr(pac_pkg::OFF_CMD_HI, v, 1'b0);
		wr(pac_pkg::OFF_CMD_CK, {24'h0, ck}, 1'b0);
		wait_idle();
		check("status", {24'h0, rv[7:0]}, {24'h0, est});
		rd(pac_pkg::OFF_ACCU);
		acc = rv;
		rd(pac_pkg::OFF_VALUE);
	endtask : cmd
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wait_idle();
	endtask : do_reset
	task automatic t_axis;
		logic [31:0] a0;
		cmd(pac_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h0000C800, 8'h00, pac_pkg::ST_OK);
		check("max_speed", max_speed, 32'h0000C800);
		a0 = acc;
		cmd(pac_pkg::GET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("gap value", rv, 32'h0000C800);
		check("accu direct", acc, a0);
		wr(pac_pkg::OFF_CTRL, 32'h1, 1'b0);
		rd(pac_pkg::OFF_CTRL);
		check("ctrl readback", rv, 32'h1);
		actual_position <= 32'h1234ABCD;
		cmd(pac_pkg::GET_AXIS_PARAM_CMD, 8'h01, 8'h00, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("gap position", rv, 32'h1234ABCD);
		check("accu standalone", acc, 32'h1234ABCD);
		wr(pac_pkg::OFF_CTRL, 32'h0, 1'b0);
		cmd(pac_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h01, 32'h7, 8'h00, pac_pkg::ST_BAD_VALUE);
	endtask : t_axis
	task automatic t_global;
		cmd(pac_pkg::SET_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 32'h3, 8'h00, pac_pkg::ST_OK);
		check("serial_addr", {24'h0, serial_addr}, 32'h3);
		check("nv copy", i_pac_cmd_top.u_nv.mem[9'h042], 32'h3);
		cmd(pac_pkg::GET_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("ggp value", rv, 32'h3);
		check("ggp accu", acc, 32'h3);
		cmd(pac_pkg::SET_GLOBAL_PARAM_CMD, 8'h00, 8'h03, 32'h5, 8'h00, pac_pkg::ST_OK);
		cmd(pac_pkg::GET_GLOBAL_PARAM_CMD, 8'h00, 8'h03, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("bank3 value", rv, 32'h5);
		cmd(pac_pkg::SET_GLOBAL_PARAM_CMD, 8'h00, 8'h01, 32'h5, 8'h00, pac_pkg::ST_BAD_VALUE);
	endtask : t_global
	task automatic t_user;
		cmd(pac_pkg::SET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0000AA55, 8'h00, pac_pkg::ST_OK);
		cmd(pac_pkg::STORE_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("store value", rv, 32'h0);
		cmd(pac_pkg::STORE_GLOBAL_PARAM_CMD, 8'h2A, 8'h00, 32'h0, 8'h00, pac_pkg::ST_BAD_VALUE);
		cmd(pac_pkg::SET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h00001111, 8'h00, pac_pkg::ST_OK);
		cmd(pac_pkg::RESTORE_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0, 8'h00, pac_pkg::ST_OK);
		cmd(pac_pkg::GET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("restored", rv, 32'h0000AA55);
	endtask : t_user
	task automatic t_frame;
		cmd(pac_pkg::SET_AXIS_PARAM_CMD, 8'h04, 8'h00, 32'h7, 8'h01, pac_pkg::ST_BAD_CKSUM);
		check("max_speed kept", max_speed, 32'h0000C800);
		rd(pac_pkg::OFF_STATUS);
		check("ckerr flag", {31'h0, rv[pac_pkg::STAT_CKERR_BIT]}, 32'h1);
		cmd(8'h03, 8'h00, 8'h00, 32'h0, 8'h00, pac_pkg::ST_BAD_CMD);
		wr(pac_pkg::OFF_VALUE, 32'h1, 1'b1);
		rd(8'h20);
		check("unmapped err", {31'h0, er}, 32'h1);
	endtask : t_frame
	task automatic t_power;
		do_reset();
		check("speed after reset", max_speed, 32'h0);
		cmd(pac_pkg::GET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0, 8'h00, pac_pkg::ST_OK);
		check("reloaded", rv, 32'h0000AA55);
	endtask : t_power
	// Main sequence.
	initial begin
		bad_count = 0;
		checks_done = 0;
		actual_position = 32'h0;
		do_reset();
		t_axis();
		t_global();
		t_user();
		t_frame();
		t_power();
		final_report();
	end
endmodule : testbench
